// ==== cpmc_top.sv ====
// mode state machine, fault latches, startup timing and bus slave
`default_nettype none
module cpmc_top
(
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 clkEn,
    input  wire logic                 turnOnInput,
    input  wire cpmc_pkg::cpmc_sense_t senseIn,
    input  wire cpmc_pkg::cpmc_input_t inputIn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic                      switchEn,
    output logic [2:0]                rampStep,
    output logic                      powerOkOut,
    output logic                      powerOkOe
);
    import cpmc_pkg::*;

    // -------------------------------------------------------------------------
    // input registers
    // -------------------------------------------------------------------------
    cpmc_sense_t sense_q;
    cpmc_input_t in_q;
    logic        turnOn_q;
    logic        turnOnPrev_q;

    // comparators and turn-on treated as synchronous, one register stage
    // no second stage: these levels are taken as already synchronous to clk
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sense_q      <= '0;
            in_q         <= 3'b111;
            turnOn_q     <= 1'b0;
            turnOnPrev_q <= 1'b0;
        end
        else if (clkEn)
        begin
            sense_q      <= senseIn;
            in_q         <= inputIn;
            turnOn_q     <= turnOnInput;
            turnOnPrev_q <= turnOn_q;
        end
    end

    // -------------------------------------------------------------------------
    // bus registers
    // -------------------------------------------------------------------------
    logic [31:0] ctrl_q, ctrl_d;
    logic        wrPend_q, wrPend_d;
    logic [31:0] wrAddr_q, wrAddr_d;
    logic [31:0] rdata_q, rdata_d;
    logic        swClear;
    logic        enEff;
    logic [4:0]  fault_q, fault_d;
    cpmc_mode_t  mode_q, mode_d;
    logic        powerOk_q, powerOk_d;
    logic        sw_q, sw_d;

    // a software enable gates the pin; a pin rising edge or a clear-bit write counts as a toggle
    assign enEff   = turnOn_q & ctrl_q[CTRL_ENABLE_BIT];
    assign swClear = wrPend_q && (wrAddr_q == CTRL_ADDR) && hwdata[CTRL_CLEAR_BIT];

    // address phase captured, write applied in data phase; always zero wait
    always_comb
    begin
        ctrl_d   = ctrl_q;
        wrPend_d = 1'b0;
        wrAddr_d = wrAddr_q;
        rdata_d  = rdata_q;
        if (wrPend_q && wrAddr_q == CTRL_ADDR)
        begin
            ctrl_d = {30'h0, hwdata[CTRL_CLEAR_BIT:0]} & 32'h0000_0001;
        end
        if (hsel && hready && htrans[1])
        begin
            wrPend_d = hwrite;
            wrAddr_d = haddr;
            if (!hwrite)
            begin
                if (haddr == CTRL_ADDR)
                    rdata_d = ctrl_q;
                else if (haddr == STATUS_ADDR)
                    rdata_d = {27'h0, sw_q, powerOk_q, mode_q};
                else if (haddr == FAULT_ADDR)
                    rdata_d = {27'h0, fault_q};
                else
                    rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q   <= CTRL_RESET;
            wrPend_q <= 1'b0;
            wrAddr_q <= 32'h0000_0000;
            rdata_q  <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            ctrl_q   <= ctrl_d;
            wrPend_q <= wrPend_d;
            wrAddr_q <= wrAddr_d;
            rdata_q  <= rdata_d;
        end
    end

    // zero-wait slave: ready and response are fixed, so there is no stall path
    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // -------------------------------------------------------------------------
    // mode machine
    // -------------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [2:0]       step_q, step_d;
    logic             toggled;
    logic             inValid;
    logic             uvTrip, ovTrip, fsTrip, hotTrip;
    logic             ramped;

    // turn-on low then high; host holds low long enough
    assign toggled = enEff & ~turnOnPrev_q | swClear;
    assign inValid = ~in_q.inputLow & ~in_q.inputHigh;
    assign uvTrip  = sense_q.posLow | sense_q.negLow;
    assign ovTrip  = sense_q.posHigh | sense_q.negHigh;
    assign fsTrip  = sense_q.failsafeHigh;
    assign hotTrip = sense_q.primaryHot | sense_q.secondaryHot;
    assign ramped  = step_q == 3'(RAMP_STEPS);

    // fault latches, mode and counters computed together
    // analog-low clear is applied last on purpose: a dead input outranks a fresh trip
    always_comb
    begin
        fault_d   = fault_q;
        mode_d    = mode_q;
        cnt_d     = cnt_q;
        step_d    = step_q;
        // failsafe latches in any running mode, feedback overvoltage in normal here and in soft at the deglitch check
        if (mode_q == MODE_SOFT || mode_q == MODE_NORMAL)
        begin
            if (fsTrip)
                fault_d[F_FS] = 1'b1;
            if (ovTrip && mode_q == MODE_NORMAL)
                fault_d[F_OV] = 1'b1;
            if (hotTrip)
                fault_d[F_HOT] = 1'b1;
        end
        case (mode_q)
            MODE_DISABLE:
            begin
                // outputs off, waiting on turn-on
                cnt_d  = '0;
                step_d = '0;
                if (enEff)
                    mode_d = MODE_SOFT;
            end
            MODE_SOFT:
            begin
                // undervoltage ignored here step reference every 128 us
                cnt_d = cnt_q + 1'b1;
                if (!ramped && cnt_q == CNT_W'(STEP_CYC - 1))
                begin
                    step_d = step_q + 1'b1;
                    cnt_d  = '0;
                end
                if (!sense_q.biasReached && !ramped && step_q == 3'(RAMP_STEPS - 1)
                    && cnt_q == CNT_W'(STEP_CYC - 1))
                    fault_d[F_TOUT] = 1'b1;
                // after ramp, deglitch window before power ok
                if (ramped && cnt_q == CNT_W'(DEGLITCH_CYC - 1))
                begin
                    if (!(sense_q.posRecovered && sense_q.negRecovered))
                        fault_d[F_UV] = 1'b1;
                    else if (ovTrip)
                        fault_d[F_OV] = 1'b1;
                    else
                        mode_d = MODE_NORMAL;
                end
                if (!enEff)
                    mode_d = MODE_DISABLE;
            end
            MODE_NORMAL:
            begin
                // overload droop and undervoltage both land here
                if (uvTrip)
                    fault_d[F_UV] = 1'b1;
                if (!enEff)
                    mode_d = MODE_DISABLE;
            end
            MODE_LATCHED:
            begin
                // stays off after cause is gone hot needs cooling
                if (toggled && (!fault_q[F_HOT] || sense_q.hotRecovered))
                begin
                    fault_d = '0;
                    mode_d  = MODE_SOFT;
                    cnt_d   = '0;
                    step_d  = '0;
                end
            end
            default:
            begin
                // auto-recovery leaves via input window only
                cnt_d  = '0;
                step_d = '0;
                mode_d = (fault_q != '0) ? MODE_LATCHED :
                         (enEff ? MODE_SOFT : MODE_DISABLE);
            end
        endcase
        if (mode_q != MODE_LATCHED && mode_q != MODE_AUTO && fault_d != '0)
            mode_d = MODE_LATCHED;
        // analog low resets all protections; overvoltage keeps them
        if (in_q.inputAnalogLow)
            fault_d = '0;
        if (!inValid)
            mode_d = MODE_AUTO;
        else if (mode_q == MODE_AUTO)
            mode_d = (fault_d != '0) ? MODE_LATCHED :
                     (enEff ? MODE_SOFT : MODE_DISABLE);
    end

    // outputs follow next mode so they come straight from flops
    always_comb
    begin
        sw_d      = (mode_d == MODE_SOFT) || (mode_d == MODE_NORMAL);
        powerOk_d = (mode_d == MODE_NORMAL);
    end

    // single binary mode register makes exactly one mode active
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_q   <= '0;
            mode_q    <= MODE_AUTO;
            cnt_q     <= '0;
            step_q    <= '0;
            powerOk_q <= 1'b0;
            sw_q      <= 1'b0;
        end
        else if (clkEn)
        begin
            fault_q   <= fault_d;
            mode_q    <= mode_d;
            cnt_q     <= cnt_d;
            step_q    <= step_d;
            powerOk_q <= powerOk_d;
            sw_q      <= sw_d;
        end
    end

    // -------------------------------------------------------------------------
    // pins
    // -------------------------------------------------------------------------
    // open drain: pulls low only when power is ok pin pull-down is analog
    // limitation: the low hold on turn-on is not timed here; any rising edge with the soft enable set clears unless a hot fault still awaits recovery
    assign switchEn   = sw_q;
    assign rampStep   = step_q;
    assign powerOkOut = 1'b0;
    assign powerOkOe  = powerOk_q;
endmodule
`default_nettype wire

// ==== cpmc_pkg.sv ====
// package for the converter protection and mode controller
`default_nettype none
package cpmc_pkg;
    // -------------------------------------------------------------------------
    // register map (byte addresses)
    // -------------------------------------------------------------------------
    localparam logic [31:0] CTRL_ADDR   = 32'h0000_0000;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
    localparam logic [31:0] FAULT_ADDR  = 32'h0000_0008;
    // control fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT  = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // status fields: mode in [2:0], power ok in [3], switching in [4]
    localparam int STAT_OK_BIT     = 3;
    localparam int STAT_SW_BIT     = 4;
    // fault cause bits
    localparam int F_UV   = 0;
    localparam int F_OV   = 1;
    localparam int F_FS   = 2;
    localparam int F_HOT  = 3;
    localparam int F_TOUT = 4;
    // -------------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int DEGLITCH_US   = 3000;
    localparam int DEGLITCH_CYC  = DEGLITCH_US * (CLK_HZ / 1_000_000);
    localparam int STEP_US       = 128;
    localparam int STEP_CYC      = STEP_US * (CLK_HZ / 1_000_000);
    localparam int RAMP_STEPS    = 7;
    localparam int TOUT_US       = 2000;
    localparam int TOUT_CYC      = TOUT_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W         = 16;
    // -------------------------------------------------------------------------
    // modes and carriers
    // -------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MODE_DISABLE = 3'b000,
        MODE_SOFT    = 3'b001,
        MODE_NORMAL  = 3'b010,
        MODE_AUTO    = 3'b011,
        MODE_LATCHED = 3'b100
    } cpmc_mode_t;
    typedef struct packed
    {
        logic posLow;
        logic negLow;
        logic posRecovered;
        logic negRecovered;
        logic posHigh;
        logic negHigh;
        logic failsafeHigh;
        logic primaryHot;
        logic secondaryHot;
        logic hotRecovered;
        logic biasReached;
    } cpmc_sense_t;
    typedef struct packed
    {
        logic inputLow;
        logic inputHigh;
        logic inputAnalogLow;
    } cpmc_input_t;
endpackage
`default_nettype wire

// ==== cpmc_monitor.sv ====
// port checker for the protection and mode controller
`default_nettype none
module cpmc_monitor
(
    input wire logic                  clk,
    input wire logic                  arst_n,
    input wire logic                  turnOnInput,
    input wire cpmc_pkg::cpmc_sense_t senseIn,
    input wire cpmc_pkg::cpmc_input_t inputIn,
    input wire logic                  switchEn,
    input wire logic [2:0]            rampStep,
    input wire logic                  powerOkOe
);
    timeunit 1ns;
    timeprecision 1ns;
    import cpmc_pkg::*;
    logic [15:0] swCnt_q;
    logic [15:0] swCnt_d;
    logic        inOk;
    // ------------------------------------------------------------
    // switching-time counter and checks
    // ------------------------------------------------------------
    // saturates so a long run never wraps into a false short count
    always_comb
    begin
        inOk = !inputIn.inputLow && !inputIn.inputHigh;
        swCnt_d = 16'h0000;
        if (switchEn)
        begin
            swCnt_d = (&swCnt_q) ? swCnt_q : swCnt_q + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            swCnt_q <= 16'h0000;
        end
        else
        begin
            swCnt_q <= swCnt_d;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // switching drops while the host keeps turn-on high
    sequence s_trip;
        $fell(switchEn) && turnOnInput && inOk;
    endsequence
    sequence s_held;
        (turnOnInput && inOk) [*8];
    endsequence
    a_ok_needs_run:
        assert property (powerOkOe |-> switchEn)
        else $error("power ok while not switching");
    a_fb_high_stop:
        assert property ((senseIn.posHigh || senseIn.negHigh) && powerOkOe |-> ##[1:4] !switchEn)
        else $error("switching after feedback high");
    a_failsafe_stop:
        assert property (senseIn.failsafeHigh && powerOkOe |-> ##[1:4] !switchEn)
        else $error("switching after failsafe high");
    a_low_stop:
        assert property ((senseIn.posLow || senseIn.negLow) && powerOkOe
            |-> ##[1:4] (!switchEn && !powerOkOe))
        else $error("running after output low");
    a_hot_stop:
        assert property ((senseIn.primaryHot || senseIn.secondaryHot) && powerOkOe
            |-> ##[1:4] (!switchEn && !powerOkOe))
        else $error("running after overtemperature");
    a_input_off:
        assert property ((!inOk) [*4] |-> !switchEn && !powerOkOe)
        else $error("running with input out of window");
    a_latch_holds:
        assert property (s_trip ##1 s_held |-> !switchEn)
        else $error("restart without a turn-on toggle");
    a_deglitch_wait:
        assert property ($rose(powerOkOe) |-> swCnt_q >= RAMP_STEPS * STEP_CYC + DEGLITCH_CYC - 2)
        else $error("power ok before ramp and deglitch");
    a_ramp_steps:
        assert property (rampStep != $past(rampStep) && rampStep != 3'h0
            |-> rampStep == $past(rampStep) + 3'h1)
        else $error("ramp step skipped");
    a_off_disable:
        assert property ((!turnOnInput) [*4] |-> !switchEn)
        else $error("switching with turn-on low");
endmodule
bind cpmc_top cpmc_monitor cpmc_monitor_i
(
    .clk(clk), .arst_n(arst_n), .turnOnInput(turnOnInput), .senseIn(senseIn),
    .inputIn(inputIn), .switchEn(switchEn), .rampStep(rampStep), .powerOkOe(powerOkOe)
);
`default_nettype wire

// ==== cpmc_host.sv ====
// host model: drives turn-on and watches the open-drain power-ok line
`default_nettype none
module cpmc_host
#(
    parameter int HOLD_CYC = 1600
)
(
    input  wire logic clk,
    input  wire logic powerOkOut,
    input  wire logic powerOkOe,
    output logic      turnOnInput,
    output logic      powerOkN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drive = 1'b0;
    logic level = 1'b0;
    // an undriven pin sinks to ground through the weak pull-down
    assign turnOnInput = drive ? level : 1'b0;
    // pull-up wins unless the device pulls the line low
    assign powerOkN = powerOkOe ? powerOkOut : 1'b1;
    // pin changes just after an edge
    task automatic setOn(input logic v);
        @(posedge clk);
        drive <= 1'b1;
        level <= v;
    endtask
    // held low well past 150 us, then high again
    task automatic toggle();
        setOn(1'b0);
        repeat (HOLD_CYC) @(posedge clk);
        level <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== test_converter_protection_mode_control.sv ====
// self-checking bench for the protection and mode controller
`default_nettype none
module test_converter_protection_mode_control;
    timeunit 1ns;
    timeprecision 1ns;
    import cpmc_pkg::*;
    localparam cpmc_sense_t RISING = 11'h603;
    localparam cpmc_sense_t GOOD   = 11'h183;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        turnOnInput;
    logic        powerOkN;
    cpmc_sense_t senseIn = RISING;
    cpmc_input_t inputIn = 3'b100;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        switchEn;
    logic [2:0]  rampStep;
    logic        powerOkOut;
    logic        powerOkOe;
    logic        rdPhase = 1'b0;
    logic [7:0]  rnd = 8'h56;
    logic [31:0] badAddr;
    logic [31:0] expQ[$];
    int          failures = 0;
    int          num_checks = 0;
    cpmc_top cpmc_top_i
    (
        .clk(clk), .arst_n(arst_n), .clkEn(1'b1), .turnOnInput(turnOnInput),
        .senseIn(senseIn), .inputIn(inputIn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .switchEn(switchEn), .rampStep(rampStep),
        .powerOkOut(powerOkOut), .powerOkOe(powerOkOe)
    );
    cpmc_host cpmc_host_i
    (
        .clk(clk), .powerOkOut(powerOkOut), .powerOkOe(powerOkOe),
        .turnOnInput(turnOnInput), .powerOkN(powerOkN)
    );
    always #50 clk = ~clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] st(input logic sw, input logic ok, input cpmc_mode_t m);
        return {27'h000_0000, sw, ok, m};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one single word transfer; waits on hready in both phases
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        expQ.push_back(e);
        xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // read data is taken at the end of its data phase
    always @(posedge clk)
    begin
        if (rdPhase && hreadyout === 1'b1)
        begin
            check(hrdata, expQ.pop_front());
        end
        rdPhase = hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
    end
    // hang guard, well past the longest expected run
    initial
    begin
        #12_000_000;
        failures++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(CTRL_ADDR, CTRL_RESET);
        rd(STATUS_ADDR, st(0, 0, MODE_AUTO));
        rnd = lfsr(rnd);
        badAddr = 32'h0000_0100 | {24'h00_0000, rnd[5:0], 2'b00};
        xfer(1'b1, badAddr, {4{rnd}});
        rd(badAddr, 32'h0000_0000);
        inputIn <= 3'b000;
        repeat (4) @(posedge clk);
        rd(STATUS_ADDR, st(0, 0, MODE_DISABLE));
        check({31'h000_0000, powerOkN}, 32'h0000_0001);
        cpmc_host_i.setOn(1'b1);
        repeat (4) @(posedge clk);
        rd(STATUS_ADDR, st(1, 0, MODE_SOFT));
        repeat (9000) @(posedge clk);
        rd(STATUS_ADDR, st(1, 0, MODE_SOFT));
        check({29'h000_0000, rampStep}, 32'(RAMP_STEPS));
        senseIn <= GOOD;
        repeat (31000) @(posedge clk);
        rd(STATUS_ADDR, st(1, 1, MODE_NORMAL));
        check({31'h000_0000, powerOkN}, 32'h0000_0000);
        senseIn.posHigh <= 1'b1;
        senseIn.failsafeHigh <= 1'b1;
        senseIn.primaryHot <= 1'b1;
        senseIn.hotRecovered <= 1'b0;
        repeat (5) @(posedge clk);
        rd(STATUS_ADDR, st(0, 0, MODE_LATCHED));
        check({31'h000_0000, powerOkN}, 32'h0000_0001);
        rd(FAULT_ADDR, 32'(1 << F_OV | 1 << F_FS | 1 << F_HOT));
        senseIn.posHigh <= 1'b0;
        senseIn.failsafeHigh <= 1'b0;
        senseIn.primaryHot <= 1'b0;
        cpmc_host_i.toggle();
        repeat (5) @(posedge clk);
        rd(STATUS_ADDR, st(0, 0, MODE_LATCHED));
        inputIn <= 3'b010;
        repeat (5) @(posedge clk);
        rd(STATUS_ADDR, st(0, 0, MODE_AUTO));
        inputIn <= 3'b000;
        repeat (5) @(posedge clk);
        rd(STATUS_ADDR, st(0, 0, MODE_LATCHED));
        senseIn <= RISING & 11'h7FE;
        cpmc_host_i.toggle();
        repeat (5) @(posedge clk);
        rd(STATUS_ADDR, st(1, 0, MODE_SOFT));
        repeat (9000) @(posedge clk);
        rd(STATUS_ADDR, st(0, 0, MODE_LATCHED));
        rd(FAULT_ADDR, 32'(1 << F_TOUT));
        senseIn <= RISING;
        cpmc_host_i.toggle();
        repeat (9000) @(posedge clk);
        senseIn <= GOOD;
        repeat (31000) @(posedge clk);
        rd(STATUS_ADDR, st(1, 1, MODE_NORMAL));
        check({31'h000_0000, powerOkN}, 32'h0000_0000);
        senseIn.posLow <= 1'b1;
        repeat (5) @(posedge clk);
        rd(STATUS_ADDR, st(0, 0, MODE_LATCHED));
        check({31'h000_0000, powerOkN}, 32'h0000_0001);
        rd(FAULT_ADDR, 32'(1 << F_UV));
        inputIn <= 3'b101;
        senseIn.posLow <= 1'b0;
        repeat (5) @(posedge clk);
        inputIn <= 3'b000;
        repeat (5) @(posedge clk);
        rd(STATUS_ADDR, st(1, 0, MODE_SOFT));
        rd(FAULT_ADDR, 32'h0000_0000);
        // clear bit is a pulse only; dropping the soft enable falls back to disable
        xfer(1'b1, CTRL_ADDR, 32'h0000_0003);
        rd(CTRL_ADDR, 32'h0000_0001);
        xfer(1'b1, CTRL_ADDR, 32'h0000_0000);
        repeat (2) @(posedge clk);
        rd(STATUS_ADDR, st(0, 0, MODE_DISABLE));
        rd(CTRL_ADDR, 32'h0000_0000);
        check({31'h000_0000, powerOkN}, 32'h0000_0001);
        @(posedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
